/* pkg/qce_pkg.sv */
// constants and types shared by the constellation encoder files
package qce_pkg;

  // ------------------------------------------------------------
  // constellation sizes and coordinate widths
  // ------------------------------------------------------------
  localparam int QCE_M_MIN = 1;
  localparam int QCE_M_MAX = 12;
  localparam int QCE_CNT_W = 4;
  localparam int QCE_GRP_W = 12;
  localparam int QCE_MAG_W = 7;
  localparam int QCE_COORD_W = 8;
  localparam int QCE_CHAIN_MAX = 5;

  // ------------------------------------------------------------
  // bit positions inside a group (b1 is the first bit received)
  // ------------------------------------------------------------
  localparam int QCE_SQ_MIN_M = 4;
  localparam int QCE_SQ_I_START = 3;
  localparam int QCE_SQ_Q_OFFSET = 2;
  localparam int QCE_CROSS_MIN_M = 5;
  localparam int QCE_CROSS_BASE = 5;
  localparam int QCE_CROSS_X_START = 6;
  localparam int QCE_SEC_B3 = 2;
  localparam int QCE_SEC_B4 = 3;
  localparam int QCE_SEC_B5 = 4;
  localparam int QCE_CROSS_COLS = 3;

  // ------------------------------------------------------------
  // quadrant codes (first..fourth) and differential steps
  // ------------------------------------------------------------
  localparam logic [1:0] QCE_QUAD_FIRST = 2'h0;
  localparam logic [1:0] QCE_QUAD_SECOND = 2'h1;
  localparam logic [1:0] QCE_QUAD_THIRD = 2'h2;
  localparam logic [1:0] QCE_QUAD_FOURTH = 2'h3;
  localparam logic [1:0] QCE_STEP_KEEP = 2'h0;
  localparam logic [1:0] QCE_STEP_FWD = 2'h1;
  localparam logic [1:0] QCE_STEP_HALF = 2'h2;
  localparam logic [1:0] QCE_STEP_BACK = 2'h3;

  // ------------------------------------------------------------
  // output buffer
  // ------------------------------------------------------------
  localparam int QCE_BUF_DEPTH = 2;
  localparam logic [1:0] QCE_BUF_FULL = 2'h2;

  // transmit clock source; zero is the safe local oscillator
  typedef enum logic [1:0] {
    QCE_SRC_LOCAL,
    QCE_SRC_NETWORK,
    QCE_SRC_LOOP
  } qce_clk_src_t;

  typedef struct packed {
    logic signed [QCE_COORD_W-1:0] i;
    logic signed [QCE_COORD_W-1:0] q;
  } qce_sym_t;

endpackage

/* pkg/qce_sym_if.sv */
// symbol handshake between the encoder core and its output buffer
interface qce_sym_if;
  logic in_valid;
  logic in_ready;
  qce_pkg::qce_sym_t in_data;
  logic out_valid;
  logic out_ready;
  qce_pkg::qce_sym_t out_data;

  modport fifo (
    input in_valid,
    input in_data,
    input out_ready,
    output in_ready,
    output out_valid,
    output out_data
  );

  modport user (
    output in_valid,
    output in_data,
    output out_ready,
    input in_ready,
    input out_valid,
    input out_data
  );
endinterface

/* verilog/qce_sym_buffer.sv */
// two-entry symbol buffer with valid/ready on both sides
module qce_sym_buffer (
  input wire logic clock,
  input wire logic rst_n,
  qce_sym_if.fifo port
);

  typedef struct packed {
    qce_pkg::qce_sym_t [qce_pkg::QCE_BUF_DEPTH-1:0] slot;
    logic wr_ptr;
    logic rd_ptr;
    logic [1:0] count;
  } qce_buf_state_t;

  qce_buf_state_t st;
  qce_buf_state_t next_st;
  logic push;
  logic pop;

  // ------------------------------------------------------------
  // handshakes straight from the occupancy count
  // ------------------------------------------------------------
  assign port.in_ready = (st.count != qce_pkg::QCE_BUF_FULL);
  assign port.out_valid = (st.count != 2'h0);
  assign port.out_data = st.slot[st.rd_ptr];
  assign push = port.in_valid && port.in_ready;
  assign pop = port.out_valid && port.out_ready;

  // write, read and count; simultaneous push and pop keeps the count
  always_comb begin
    next_st = st;
    if (push) begin
      next_st.slot[st.wr_ptr] = port.in_data;
      next_st.wr_ptr = ~st.wr_ptr;
    end
    if (pop) begin
      next_st.rd_ptr = ~st.rd_ptr;
    end
    case ({push, pop})
      2'b10: next_st.count = st.count + 2'h1;
      2'b01: next_st.count = st.count - 2'h1;
      default: next_st.count = st.count;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_buf_no_overrun: assert property (@(posedge clock) disable iff (!rst_n)
    (st.count == qce_pkg::QCE_BUF_FULL) && !pop |=> !port.in_ready && $stable(st.slot))
    else $error("buffer accepted a word while full");

  a_buf_keeps_word: assert property (@(posedge clock) disable iff (!rst_n)
    port.out_valid && !port.out_ready |=> port.out_valid && $stable(port.out_data))
    else $error("buffer dropped or changed a stalled word");

endmodule

/* verilog/qce_encoder.sv */
// serial-bit to I/Q constellation encoder with transmit clock source selection
//
// Summary of operation
// - bits arrive serially, first bit is b1, and each run of M bits becomes one symbol in order.
// - every symbol leaves as one in-phase and one quadrature coordinate side by side.
// - the first bits of a group give a quadrant step from the previous symbol, not a fixed quadrant.
// - with M=1 a 0 keeps the quadrant and a 1 steps two quadrants, first to third or second to fourth and back.
// - with M>1 the pair 00 keeps, 10 steps forward one, 11 steps two, 01 steps back one.
// - from M=4 up the bits after the quadrant pair pick the point inside the quadrant; sizes 1..3 stay at the unit point.
// - square sizes take I as a chained run from b3 to b(M/2+1) ending in a 1.
// - square sizes take Q as a chained run from b(M/2+2) to bM ending in a 1.
// - cross sizes split the quadrant into eight sections chosen by b3 b4 b5.
// - each section has a fixed row, column, horizontal flip and vertical flip.
// - cross sizes above 5 place the point in a section by two chained runs ending in a 1.
// - the second, third and fourth quadrants are the first rotated by 90, 180 and 270 degrees.
// - on the network side the transmit clock follows the network clock, else the local one.
// - on the remote side the transmit clock is loop-timed, falling back to the local one when lost.
module qce_encoder (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic bit_data,
  input wire logic bit_valid,
  output logic bit_ready,
  input wire logic [3:0] m_size,
  input wire logic network_side_transceiver,
  input wire logic network_clock_ok,
  input wire logic recovered_clock_ok,
  output logic [1:0] clk_src,
  output logic [7:0] sym_i,
  output logic [7:0] sym_q,
  output logic sym_valid,
  input wire logic sym_ready
);

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------

  // out-of-range sizes fall back to one bit per symbol
  function automatic logic [3:0] qce_m_eff(input logic [3:0] m);
    if ((m < 4'(qce_pkg::QCE_M_MIN)) || (m > 4'(qce_pkg::QCE_M_MAX))) begin
      qce_m_eff = 4'h1;
    end else begin
      qce_m_eff = m;
    end
  endfunction

  // chained coordinate: len bits from b(start), each folded into the last, then a 1
  function automatic logic [6:0] qce_chain(input logic [11:0] g, input int start, input int len);
    logic [6:0] v;
    logic x;
    v = 7'h00;
    x = 1'b0;
    for (int k = 0; k < qce_pkg::QCE_CHAIN_MAX; k++) begin
      if (k < len) begin
        x = (k == 0) ? g[start - 1] : (x ^ g[start - 1 + k]);
        v = {v[5:0], x};
      end
    end
    qce_chain = {v[5:0], 1'b1};
  endfunction

  // section code -> {row, column, horizontal flip, vertical flip}
  function automatic logic [5:0] qce_section(input logic [2:0] code);
    case (code)
      3'h0: qce_section = {2'h0, 2'h0, 1'b0, 1'b0};
      3'h1: qce_section = {2'h0, 2'h1, 1'b0, 1'b1};
      3'h3: qce_section = {2'h0, 2'h2, 1'b0, 1'b1};
      3'h4: qce_section = {2'h1, 2'h0, 1'b1, 1'b0};
      3'h5: qce_section = {2'h1, 2'h1, 1'b1, 1'b1};
      3'h7: qce_section = {2'h1, 2'h2, 1'b1, 1'b1};
      3'h6: qce_section = {2'h2, 2'h0, 1'b1, 1'b0};
      3'h2: qce_section = {2'h2, 2'h1, 1'b1, 1'b1};
      default: qce_section = 6'h00;
    endcase
  endfunction

  // section offset: index times section width, index is 0..2
  function automatic logic [6:0] qce_offset(input logic [1:0] idx, input logic [6:0] width);
    case (idx)
      2'h1: qce_offset = width;
      2'h2: qce_offset = {width[5:0], 1'b0};
      default: qce_offset = 7'h00;
    endcase
  endfunction

  function automatic logic [7:0] qce_abs(input logic signed [7:0] v);
    qce_abs = v[7] ? 8'(-v) : 8'(v);
  endfunction

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [11:0] grp;
    logic [3:0] cnt;
    logic [3:0] m_cur;
    logic [1:0] quad;
    logic pend;
    logic [3:0] pend_m;
    qce_pkg::qce_sym_t pend_sym;
    logic [1:0] role_sync;
    logic [1:0] net_sync;
    logic [1:0] rx_sync;
    qce_pkg::qce_clk_src_t src;
  } qce_enc_state_t;

  qce_enc_state_t st;
  qce_enc_state_t next_st;

  qce_sym_if ifc ();

  logic take;
  logic is_last;
  logic [3:0] m_now;
  logic [11:0] g_full;
  logic [1:0] step;
  logic [1:0] new_quad;
  logic [6:0] mag_x;
  logic [6:0] mag_y;
  qce_pkg::qce_sym_t new_sym;

  // ------------------------------------------------------------
  // bit intake
  // ------------------------------------------------------------

  // size is sampled on a group's first bit so a change never splits a symbol
  assign m_now = (st.cnt == 4'h0) ? qce_m_eff(m_size) : st.m_cur;
  // a held symbol stalls intake only while the buffer is also full
  assign bit_ready = !st.pend || ifc.in_ready;
  assign take = bit_valid && bit_ready;
  assign is_last = (st.cnt == (m_now - 4'h1));

  // group as it stands once the incoming bit is placed; b1 sits at index 0
  always_comb begin
    g_full = st.grp;
    g_full[st.cnt] = bit_data;
  end

  // ------------------------------------------------------------
  // symbol mapping
  // ------------------------------------------------------------

  // differential quadrant step from the leading bit or bit pair
  always_comb begin
    if (m_now == 4'h1) begin
      step = g_full[0] ? qce_pkg::QCE_STEP_HALF : qce_pkg::QCE_STEP_KEEP;
    end else begin
      case ({g_full[0], g_full[1]})
        2'b10: step = qce_pkg::QCE_STEP_FWD;
        2'b11: step = qce_pkg::QCE_STEP_HALF;
        2'b01: step = qce_pkg::QCE_STEP_BACK;
        default: step = qce_pkg::QCE_STEP_KEEP;
      endcase
    end
    new_quad = st.quad + step;
  end

  // first-quadrant magnitudes; sizes 1..3 and 2 stay at the unit point
  always_comb begin
    int half_len;
    int odd_len;
    logic [6:0] loc_x;
    logic [6:0] loc_y;
    logic [6:0] width;
    logic [5:0] sec;
    half_len = 0;
    odd_len = 0;
    loc_x = 7'h01;
    loc_y = 7'h01;
    width = 7'h02;
    sec = 6'h00;
    mag_x = 7'h01;
    mag_y = 7'h01;
    if ((m_now >= 4'(qce_pkg::QCE_SQ_MIN_M)) && !m_now[0]) begin
      half_len = int'(m_now) / 2 - 1;
      mag_x = qce_chain(g_full, qce_pkg::QCE_SQ_I_START, half_len);
      mag_y = qce_chain(g_full, int'(m_now) / 2 + qce_pkg::QCE_SQ_Q_OFFSET, half_len);
    end else if ((m_now >= 4'(qce_pkg::QCE_CROSS_MIN_M)) && m_now[0]) begin
      odd_len = (int'(m_now) - qce_pkg::QCE_CROSS_BASE) / 2;
      loc_x = qce_chain(g_full, qce_pkg::QCE_CROSS_X_START, odd_len);
      loc_y = qce_chain(g_full, odd_len + qce_pkg::QCE_CROSS_X_START, odd_len);
      width = 7'h01 << (odd_len + 1);
      sec = qce_section({g_full[qce_pkg::QCE_SEC_B3], g_full[qce_pkg::QCE_SEC_B4],
                         g_full[qce_pkg::QCE_SEC_B5]});
      // mirroring inside a section keeps odd points odd: w - x with x odd
      if (sec[1]) begin
        loc_x = width - loc_x;
      end
      if (sec[0]) begin
        loc_y = width - loc_y;
      end
      mag_x = qce_offset(sec[3:2], width) + loc_x;
      mag_y = qce_offset(sec[5:4], width) + loc_y;
    end
  end

  // rotate the first-quadrant point counter-clockwise into its quadrant
  always_comb begin
    logic signed [7:0] px;
    logic signed [7:0] py;
    px = {1'b0, mag_x};
    py = {1'b0, mag_y};
    case (new_quad)
      qce_pkg::QCE_QUAD_SECOND: begin
        new_sym.i = -py;
        new_sym.q = px;
      end
      qce_pkg::QCE_QUAD_THIRD: begin
        new_sym.i = -px;
        new_sym.q = -py;
      end
      qce_pkg::QCE_QUAD_FOURTH: begin
        new_sym.i = py;
        new_sym.q = -px;
      end
      default: begin
        new_sym.i = px;
        new_sym.q = py;
      end
    endcase
  end

  // ------------------------------------------------------------
  // next state: intake, hand-off to the buffer, clock source
  // ------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.role_sync = {st.role_sync[0], network_side_transceiver};
    next_st.net_sync = {st.net_sync[0], network_clock_ok};
    next_st.rx_sync = {st.rx_sync[0], recovered_clock_ok};
    if (st.pend && ifc.in_ready) begin
      next_st.pend = 1'b0;
    end
    if (take) begin
      next_st.m_cur = m_now;
      if (is_last) begin
        next_st.grp = 12'h000;
        next_st.cnt = 4'h0;
        next_st.quad = new_quad;
        next_st.pend = 1'b1;
        next_st.pend_m = m_now;
        next_st.pend_sym = new_sym;
      end else begin
        next_st.grp = g_full;
        next_st.cnt = st.cnt + 4'h1;
      end
    end
    // the remote side goes loop-timed as soon as the synced recovered clock is good, else local
    if (st.role_sync[1]) begin
      next_st.src = st.net_sync[1] ? qce_pkg::QCE_SRC_NETWORK : qce_pkg::QCE_SRC_LOCAL;
    end else begin
      next_st.src = st.rx_sync[1] ? qce_pkg::QCE_SRC_LOOP : qce_pkg::QCE_SRC_LOCAL;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ------------------------------------------------------------
  // output buffer and ports
  // ------------------------------------------------------------
  assign ifc.in_valid = st.pend;
  assign ifc.in_data = st.pend_sym;
  assign ifc.out_ready = sym_ready;
  assign sym_valid = ifc.out_valid;
  assign sym_i = ifc.out_data.i;
  assign sym_q = ifc.out_data.q;
  assign clk_src = st.src;

  qce_sym_buffer u_buffer (
    .clock(clock),
    .rst_n(rst_n),
    .port(ifc.fifo)
  );

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  sequence s_group_end;
    take && is_last;
  endsequence

  sequence s_pair(logic [1:0] pair);
    take && is_last && (m_now > 4'h1) && ({g_full[0], g_full[1]} == pair);
  endsequence

  a_group_to_symbol: assert property (s_group_end |=> st.pend && (st.cnt == 4'h0))
    else $error("completed group did not produce a symbol");

  a_symbol_held: assert property (st.pend && !ifc.in_ready |=> st.pend && $stable(st.pend_sym))
    else $error("stalled symbol was lost or changed");

  a_sign_of_quad: assert property (st.pend |->
    (st.pend_sym.i[7] == ((st.quad == qce_pkg::QCE_QUAD_SECOND) || (st.quad == qce_pkg::QCE_QUAD_THIRD)))
    && (st.pend_sym.q[7] == ((st.quad == qce_pkg::QCE_QUAD_THIRD) || (st.quad == qce_pkg::QCE_QUAD_FOURTH))))
    else $error("symbol signs disagree with quadrant");

  a_single_toggle: assert property (s_group_end and (m_now == 4'h1) && bit_data
    |=> st.quad == 2'($past(st.quad) + 2'h2))
    else $error("one-bit symbol did not swap quadrant");

  a_pair_keep: assert property (s_pair(2'b00) |=> st.quad == $past(st.quad))
    else $error("pair 00 moved the quadrant");

  a_pair_back: assert property (s_pair(2'b01) |=> st.quad == 2'($past(st.quad) - 2'h1))
    else $error("pair 01 did not step back one quadrant");

  a_odd_coords: assert property (st.pend |-> st.pend_sym.i[0] && st.pend_sym.q[0])
    else $error("coordinate is not an odd amplitude");

  a_square_bound: assert property (st.pend && !st.pend_m[0] && (st.pend_m >= 4'h4) |->
    (qce_abs(st.pend_sym.i) < (8'h01 << (st.pend_m >> 1)))
    && (qce_abs(st.pend_sym.q) < (8'h01 << (st.pend_m >> 1))))
    else $error("square point outside its constellation");

  a_cross_bound: assert property (st.pend && st.pend_m[0] && (st.pend_m >= 4'h5) |->
    (qce_abs(st.pend_sym.i) < (8'h03 << ((st.pend_m - 4'h3) >> 1)))
    && (qce_abs(st.pend_sym.q) < (8'h03 << ((st.pend_m - 4'h3) >> 1))))
    else $error("cross point outside its constellation");

  a_network_clock: assert property (st.role_sync[1] && st.net_sync[1] |=>
    st.src == qce_pkg::QCE_SRC_NETWORK)
    else $error("network side not on network clock");

  a_remote_fallback: assert property (!st.role_sync[1] |=>
    st.src == ($past(st.rx_sync[1]) ? qce_pkg::QCE_SRC_LOOP : qce_pkg::QCE_SRC_LOCAL))
    else $error("remote side clock source wrong");

endmodule

/* verification/qce_mod_sink.sv */
// symbol consumer standing in for the modulator, with selectable back-pressure
module qce_mod_sink (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [1:0] stall_mode,
  output logic sym_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  // ready is only driven from the falling edge; reset is still low when it first settles
  logic [31:0] lfsr = 32'h0000_9E37;

  // ------------------------------------------------------------
  // ready generation
  // ------------------------------------------------------------
  // moved on the falling edge so the encoder always samples a settled level
  always @(negedge clock) begin
    lfsr = lfsr ^ (lfsr << 13);
    lfsr = lfsr ^ (lfsr >> 17);
    lfsr = lfsr ^ (lfsr << 5);
    if (!rst_n || stall_mode == 2'h2) begin
      sym_ready <= 1'b0;
    end else if (stall_mode == 2'h1) begin
      sym_ready <= lfsr[0] | lfsr[1]; // about one cycle in four stalls
    end else begin
      sym_ready <= 1'b1;
    end
  end
endmodule

/* verification/tb.sv */
// self-checking bench for the constellation encoder
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin error_cnt++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); end end

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, rst_n, bit_data, bit_valid, bit_ready, sym_valid, sym_ready;
  logic [3:0] m_size;
  logic network_side_transceiver, network_clock_ok, recovered_clock_ok;
  logic [1:0] clk_src, stall_mode, quad;
  logic [7:0] sym_i, sym_q;
  logic [15:0] exp_q[$];
  logic [15:0] e;
  logic [31:0] seed;
  int error_cnt, n_compared;

  qce_encoder qce_encoder_inst (.clock(clock), .rst_n(rst_n), .bit_data(bit_data), .bit_valid(bit_valid),
    .bit_ready(bit_ready), .m_size(m_size), .network_side_transceiver(network_side_transceiver),
    .network_clock_ok(network_clock_ok), .recovered_clock_ok(recovered_clock_ok), .clk_src(clk_src),
    .sym_i(sym_i), .sym_q(sym_q), .sym_valid(sym_valid), .sym_ready(sym_ready));
  qce_mod_sink qce_mod_sink_inst (.clock(clock), .rst_n(rst_n), .stall_mode(stall_mode), .sym_ready(sym_ready));

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  // ------------------------------------------------------------
  // reference functions
  // ------------------------------------------------------------
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] r;
    r = s ^ (s << 13);
    r = r ^ (r >> 17);
    return r ^ (r << 5);
  endfunction

  // n chained bits from position p, each xor-ed onto the last, then a closing 1
  function automatic int chain(input logic [1:12] b, input int p, input int n);
    int v;
    logic x;
    v = 0;
    x = 1'b0;
    for (int k = 0; k < n; k++) begin
      x = (k == 0) ? b[p] : (x ^ b[p + k]);
      v = (v << 1) | int'(x);
    end
    return (v << 1) | 1;
  endfunction

  function automatic logic [1:0] next_quad(input int m, input logic [1:12] b, input logic [1:0] q);
    if (m == 1) return q + (b[1] ? 2'h2 : 2'h0);
    case ({b[1], b[2]})
      2'b00: return q;
      2'b10: return q + 2'h1;
      2'b11: return q + 2'h2;
      default: return q + 2'h3;
    endcase
  endfunction

  // section rows, columns and flips indexed by the section code b3 b4 b5
  function automatic logic [15:0] exp_point(input int m, input logic [1:12] b, input logic [1:0] q);
    int x, y, w, n, s;
    int rows[8] = '{0, 0, 2, 0, 1, 1, 2, 1};
    int cols[8] = '{0, 1, 1, 2, 0, 1, 0, 2};
    logic [7:0] hmask = 8'hF4;
    logic [7:0] vmask = 8'hAE;
    x = 1;
    y = 1;
    if (m >= 4 && m % 2 == 0) begin
      x = chain(b, 3, m / 2 - 1);
      y = chain(b, m / 2 + 2, m / 2 - 1);
    end else if (m >= 5) begin
      n = (m - 5) / 2;
      w = 2 << n;
      s = int'({b[3], b[4], b[5]});
      if (n > 0) x = chain(b, 6, n);
      if (n > 0) y = chain(b, n + 6, n);
      if (hmask[s]) x = w - x;
      if (vmask[s]) y = w - y;
      x = x + cols[s] * w;
      y = y + rows[s] * w;
    end
    case (q)
      2'h0: return {8'(x), 8'(y)};
      2'h1: return {8'(-y), 8'(x)};
      2'h2: return {8'(-x), 8'(-y)};
      default: return {8'(y), 8'(-x)};
    endcase
  endfunction

  // ------------------------------------------------------------
  // drivers
  // ------------------------------------------------------------
  task automatic final_report();
    if (error_cnt == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // bit held until a rising edge sees ready; a stuck ready ends the run
  task automatic send_bit(input logic [3:0] ms, input logic d);
    int t;
    @(negedge clock);
    m_size = ms;
    bit_valid = 1'b1;
    bit_data = d;
    t = 0;
    #1;
    while (bit_ready !== 1'b1 && t < 200) begin
      @(negedge clock);
      #1;
      t++;
    end
    if (t >= 200) begin
      error_cnt++;
      final_report();
    end
    @(posedge clock);
  endtask

  task automatic send_group(input logic [3:0] ms, input logic [1:12] b);
    int m;
    m = (ms == 4'h0 || ms > 4'hC) ? 1 : int'(ms);
    quad = next_quad(m, b, quad);
    exp_q.push_back(exp_point(m, b, quad));
    for (int k = 1; k <= m; k++) send_bit(ms, b[k]);
  endtask

  task automatic idle();
    @(negedge clock);
    bit_valid = 1'b0;
  endtask

  // every accepted symbol must be the next expected one, in group order
  always @(posedge clock) begin
    if (rst_n === 1'b1 && sym_valid === 1'b1 && sym_ready === 1'b1) begin
      if (exp_q.size() == 0) begin
        `CHK(1'b1, 1'b0)
      end else begin
        e = exp_q.pop_front();
        `CHK({sym_i, sym_q}, e)
      end
    end
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    int t;
    {rst_n, bit_data, bit_valid, stall_mode, quad} = '0;
    {network_side_transceiver, network_clock_ok, recovered_clock_ok} = 3'h0;
    m_size = 4'h1;
    seed = 32'h3FDE;
    error_cnt = 0;
    n_compared = 0;
    repeat (3) @(negedge clock);
    `CHK({bit_ready, sym_valid, clk_src, sym_i, sym_q}, 20'h80000)
    rst_n = 1'b1;
    // clock source for every side and clock-status combination
    for (int k = 0; k < 8; k++) begin
      @(negedge clock);
      {network_side_transceiver, network_clock_ok, recovered_clock_ok} = 3'(k);
      repeat (5) @(negedge clock);
      `CHK(clk_src, k[2] ? (k[1] ? 2'h1 : 2'h0) : (k[0] ? 2'h2 : 2'h0))
    end
    send_group(4'h2, 12'b10_0000000000);
    for (int k = 0; k < 4; k++) send_group(4'h1, 12'(k % 3 == 0) << 11);
    for (int k = 0; k < 16; k++) send_group(4'h2, {2'(k), 10'h0});
    send_group(4'h6, 12'b00_0001_000000);
    for (int k = 0; k < 8; k++) begin
      send_group(4'h5, {2'(k), 3'(k), 7'h0});
      send_group(4'h7, {2'(k + 1), 3'(k), 2'(k), 5'h0});
    end
    // consumer stalled: two buffered plus one pending must refuse the next bit
    idle();
    // drain the last cross symbol first, or a leftover word fills the buffer one group early
    repeat (4) @(negedge clock);
    stall_mode = 2'h2;
    for (int k = 0; k < 3; k++) send_group(4'h1, 12'h800);
    idle();
    repeat (4) @(negedge clock);
    `CHK({bit_ready, sym_valid}, 2'b01)
    stall_mode = 2'h1;
    for (int k = 0; k < 400; k++) begin
      seed = xorshift(seed);
      send_group(seed[3:0], seed[31:20]);
      if (seed[4]) idle();
    end
    idle();
    stall_mode = 2'h0;
    t = 0;
    while (exp_q.size() != 0 && t < 100) begin
      @(negedge clock);
      t++;
    end
    `CHK(exp_q.size(), 0)
    final_report();
  end
endmodule
